// *** timer8_waveform.sv ***
// 8-bit timer with two compare channels, waveform modes and axi-lite regs
// How it works
// RULE1: nonzero output mode puts compare output state on the channel pin
// RULE2: pin drive enable always follows the pin direction bit
// RULE3: pin override depends on output mode only, not waveform mode
// RULE4: output mode zero leaves compare output state unchanged on match
// RULE5: new output mode acts first at the next compare match
// RULE6: force strobe in non-pwm modes applies the action at once
// RULE7: waveform mode sets counting; output mode sets only the action
// RULE8: mode 0 counts up only and wraps ff to 00
// RULE9: normal mode sets overflow flag as counter becomes zero
// RULE10: serviced overflow interrupt clears the overflow flag
// RULE11: counter may be written at any time
// RULE12: mode 2 clears counter after it equals compare value a
// RULE13: ctc compare a written below count runs on through wrap
// RULE14: ctc sets channel a match flag every period
// RULE15: ctc output mode 1 on channel a toggles on each match
// RULE16: ctc sets overflow flag when counter wraps max to 00; code leaves it clear when compare a is ff and the match clears the counter
// RULE17: modes 3 and 7 are fast pwm, top ff or compare a
// RULE18: fast pwm clears counter the tick after it equals top
// RULE19: fast pwm mode 2 clears on match sets at bottom, 3 inverts
// RULE20: fast pwm sets overflow flag each time counter reaches top
// RULE21: compare bottom gives one-tick spike, max gives constant level
// RULE22: fast pwm output mode 1 toggles per match, still buffered
// RULE23: pwm compare writes are buffered and loaded at top
// RULE24: match sets flag at next tick; service or write one clears
// RULE25: clock select zero stops counting, counter stays accessible
// RULE26: counter write blocks all matches at the next tick
`default_nettype none
module timer8_waveform (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        timer_tick,
	input  wire logic [2:0]  flag_serviced,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             pin_a_out,
	output logic             pin_a_oe,
	output logic             pin_b_out,
	output logic             pin_b_oe
);
	// bus slave state
	logic                aw_held_r;
	logic                w_held_r;
	logic [7:0]          awaddr_r;
	logic [31:0]         wdata_r;
	logic [3:0]          wstrb_r;
	// timer state
	timer8_pkg::ctrl_t   ctrl_r;
	logic [7:0]          cnt_r;
	logic [1:0][7:0]     ocr_r;
	logic [1:0][7:0]     ocr_buf_r;
	logic [1:0]          oc_r;
	logic [2:0]          flags_r;
	logic [1:0]          pend_r;
	logic                block_r;
	logic [1:0]          port_val_r;
	logic [1:0]          port_dir_r;

	// write side decode
	wire         wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
	wire         lane0   = wr_go && wstrb_r[0];
	wire         lane1   = wr_go && wstrb_r[1];
	wire         wr_ctrl = awaddr_r == timer8_pkg::CTRL_OFS;
	wire         wr_cnt  = lane0 && awaddr_r == timer8_pkg::COUNT_OFS;
	wire         wr_oca  = lane0 && awaddr_r == timer8_pkg::CMP_A_OFS;
	wire         wr_ocb  = lane0 && awaddr_r == timer8_pkg::CMP_B_OFS;
	wire         wr_flg  = lane0 && awaddr_r == timer8_pkg::FLAGS_OFS;
	wire         wr_frc  = lane0 && awaddr_r == timer8_pkg::FORCE_OFS;
	wire         wr_port = lane0 && awaddr_r == timer8_pkg::PORT_OFS;
	wire         wr_hit  = awaddr_r[7:5] == 3'h0 && awaddr_r[1:0] == 2'h0;
	wire [1:0]   wr_ocr  = {wr_ocb, wr_oca};
	wire [1:0]   force_s = wr_frc ? wdata_r[1:0] : 2'h0;

	// mode decode
	timer8_pkg::wave_mode_t wmode;
	assign wmode = timer8_pkg::wave_mode_t'(ctrl_r.waveform_mode_select);
	wire         is_ctc  = wmode == timer8_pkg::WM_CTC;
	wire         is_pwm  = wmode == timer8_pkg::WM_FAST
		|| wmode == timer8_pkg::WM_FASTA;
	wire [1:0][1:0] com  = {ctrl_r.channel_b_output_mode,
		ctrl_r.channel_a_output_mode};
	// counting runs only with a clock source selected [RULE25]
	wire         tick    = timer_tick
		&& ctrl_r.clock_select_field != timer8_pkg::CS_STOP;
	// top is compare a in modes 2 and 7, else max [RULE17]
	wire [7:0]   top     = (is_ctc || wmode == timer8_pkg::WM_FASTA)
		? ocr_r[0] : timer8_pkg::CNT_MAX;
	wire         at_top  = cnt_r == top;
	wire         at_max  = cnt_r == timer8_pkg::CNT_MAX;
	// matches are blocked one tick after a counter write [RULE26]
	wire [1:0]   match;
	assign match[0] = tick && !block_r && cnt_r == ocr_r[0];
	assign match[1] = tick && !block_r && cnt_r == ocr_r[1];
	wire         wrap    = tick && is_pwm && at_top;

	// counter next value, sequence from waveform mode only [RULE7]
	logic [7:0]  cnt_nxt;
	logic        ovf_set;
	always_comb begin
		cnt_nxt = cnt_r;
		ovf_set = 1'b0;
		if (tick) begin
			unique case (wmode)
				timer8_pkg::WM_CTC: begin
					// clear on match with a, else run on past it [RULE12] [RULE13]
					cnt_nxt = match[0] ? timer8_pkg::CNT_BOTTOM
						: 8'(cnt_r + 8'h01);
					ovf_set = at_max && !match[0]; // [RULE16]
				end
				timer8_pkg::WM_FAST, timer8_pkg::WM_FASTA: begin
					// back to bottom the tick after top [RULE18]
					cnt_nxt = at_top ? timer8_pkg::CNT_BOTTOM
						: 8'(cnt_r + 8'h01);
					ovf_set = at_top; // [RULE20]
				end
				default: begin
					// plain up count with wrap [RULE8]
					cnt_nxt = 8'(cnt_r + 8'h01);
					ovf_set = at_max; // [RULE9]
				end
			endcase
		end
		if (wr_cnt)
			cnt_nxt = wdata_r[7:0]; // [RULE11]
	end

	// compare output state per channel
	logic [1:0]  oc_nxt;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			oc_nxt[i] = oc_r[i];
			if (is_pwm) begin
				// wrap wins so max compare holds a steady level [RULE21]
				if (wrap && com[i][1])
					oc_nxt[i] = ~com[i][0]; // [RULE19]
				else if (match[i]) begin
					unique case (com[i])
						timer8_pkg::COM_TOGGLE: oc_nxt[i] = ~oc_r[i]; // [RULE22]
						timer8_pkg::COM_CLEAR:  oc_nxt[i] = 1'b0; // [RULE19]
						timer8_pkg::COM_SET:    oc_nxt[i] = 1'b1;
						timer8_pkg::COM_OFF:    oc_nxt[i] = oc_r[i]; // [RULE4]
					endcase
				end
			end else if (match[i] || force_s[i]) begin
				// current mode bits act on this match [RULE5] [RULE6]
				unique case (com[i])
					timer8_pkg::COM_TOGGLE: oc_nxt[i] = ~oc_r[i]; // [RULE15]
					timer8_pkg::COM_CLEAR:  oc_nxt[i] = 1'b0;
					timer8_pkg::COM_SET:    oc_nxt[i] = 1'b1;
					timer8_pkg::COM_OFF:    oc_nxt[i] = oc_r[i]; // [RULE4]
				endcase
			end
		end
	end

	// flags: hardware set wins over clear [RULE24] [RULE10]
	wire [2:0]   flag_set = {pend_r[1] & tick, pend_r[0] & tick, ovf_set};
	wire [2:0]   flag_clr = flag_serviced | (wr_flg ? wdata_r[2:0] : 3'h0);
	wire [2:0]   flags_nxt = (flags_r & ~flag_clr) | flag_set; // [RULE14]

	// read mux
	wire [7:0]   rd_a    = s_axi_araddr;
	wire         rd_hit  = rd_a[7:5] == 3'h0 && rd_a[1:0] == 2'h0;
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_a)
			timer8_pkg::CTRL_OFS:  rd_data = {16'h0000, ctrl_r};
			timer8_pkg::COUNT_OFS: rd_data = {24'h00_0000, cnt_r};
			timer8_pkg::CMP_A_OFS: rd_data = {24'h00_0000, ocr_buf_r[0]};
			timer8_pkg::CMP_B_OFS: rd_data = {24'h00_0000, ocr_buf_r[1]};
			timer8_pkg::FLAGS_OFS: rd_data = {29'h0000_0000, flags_r};
			timer8_pkg::PORT_OFS:  rd_data = {28'h000_0000, port_dir_r,
				port_val_r};
			timer8_pkg::STATE_OFS: rd_data = {30'h0000_0000, oc_r};
			default:               rd_data = 32'h0000_0000;
		endcase
	end

	// axi write channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= timer8_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? timer8_pkg::RESP_OKAY
					: timer8_pkg::RESP_SLVERR;
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi read channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= timer8_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_hit ? timer8_pkg::RESP_OKAY
					: timer8_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// control and port registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r     <= timer8_pkg::CTRL_RESET;
			port_val_r <= 2'h0;
			port_dir_r <= 2'h0;
		end else begin
			if (lane0 && wr_ctrl)
				ctrl_r[7:0] <= wdata_r[7:0];
			if (lane1 && wr_ctrl)
				ctrl_r[10:8] <= wdata_r[10:8];
			if (wr_port) begin
				port_val_r <= wdata_r[1:0];
				port_dir_r <= wdata_r[3:2];
			end
		end
	end

	// counter, compare and flag state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r     <= 8'h00;
			ocr_r     <= 16'h0000;
			ocr_buf_r <= 16'h0000;
			oc_r      <= 2'h0;
			flags_r   <= 3'h0;
			pend_r    <= 2'h0;
			block_r   <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			oc_r    <= oc_nxt;
			flags_r <= flags_nxt;
			// set on match, raised as flag at the next tick [RULE24]
			pend_r  <= match | (pend_r & {2{!tick}});
			// block held until the next tick consumes it [RULE26]
			block_r <= wr_cnt || (block_r && !tick);
			for (int i = 0; i < 2; i++) begin
				if (wr_ocr[i])
					ocr_buf_r[i] <= wdata_r[7:0];
				// direct in non-pwm, loaded at top in pwm [RULE23]
				if (wr_ocr[i] && !is_pwm)
					ocr_r[i] <= wdata_r[7:0];
				else if (is_pwm && wrap)
					ocr_r[i] <= ocr_buf_r[i];
				else if (!is_pwm)
					ocr_r[i] <= ocr_buf_r[i];
			end
		end
	end

	// pin override from output mode bits alone [RULE1] [RULE3]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_a_out <= 1'b0;
			pin_b_out <= 1'b0;
			pin_a_oe  <= 1'b0;
			pin_b_oe  <= 1'b0;
		end else begin
			pin_a_out <= com[0] != timer8_pkg::COM_OFF ? oc_r[0]
				: port_val_r[0];
			pin_b_out <= com[1] != timer8_pkg::COM_OFF ? oc_r[1]
				: port_val_r[1];
			pin_a_oe  <= port_dir_r[0]; // [RULE2]
			pin_b_oe  <= port_dir_r[1];
		end
	end

	// helper state for the checks: write or match still waiting for a tick
	logic        chk_wr_r;
	logic        chk_ma_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chk_wr_r <= 1'b0;
			chk_ma_r <= 1'b0;
		end else begin
			chk_wr_r <= wr_cnt || (chk_wr_r && !tick);
			chk_ma_r <= match[0] || (chk_ma_r && !tick);
		end
	end

	// checks
	property p_ovf_normal;
		@(posedge clk) disable iff (rst)
		tick && wmode == timer8_pkg::WM_NORMAL && at_max && !wr_cnt
			|=> flags_r[timer8_pkg::FLAG_OVF] && cnt_r == 8'h00;
	endproperty
	a_ovf_normal: assert property (p_ovf_normal) // [RULE9]
		else $error("overflow not set on wrap");
	property p_ctc_clear;
		@(posedge clk) disable iff (rst)
		is_ctc && match[0] && !wr_cnt |=> cnt_r == 8'h00;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) // [RULE12]
		else $error("ctc did not clear on match");
	property p_block;
		@(posedge clk) disable iff (rst)
		chk_wr_r && tick |-> match == 2'h0;
	endproperty
	a_block: assert property (p_block) // [RULE26]
		else $error("match after counter write");
	property p_stop;
		@(posedge clk) disable iff (rst)
		ctrl_r.clock_select_field == timer8_pkg::CS_STOP && !wr_cnt
			|=> $stable(cnt_r);
	endproperty
	a_stop: assert property (p_stop) // [RULE25]
		else $error("counter moved while stopped");
	property p_pin_dir;
		@(posedge clk) disable iff (rst)
		##1 pin_a_oe == $past(port_dir_r[0]);
	endproperty
	a_pin_dir: assert property (p_pin_dir) // [RULE2]
		else $error("pin enable not from direction");
	property p_override;
		@(posedge clk) disable iff (rst)
		com[0] != timer8_pkg::COM_OFF |=> pin_a_out == $past(oc_r[0]);
	endproperty
	a_override: assert property (p_override) // [RULE1]
		else $error("pin not overridden");
	property p_fast_wrap;
		@(posedge clk) disable iff (rst)
		wrap && !wr_cnt |=> cnt_r == 8'h00;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) // [RULE18]
		else $error("fast pwm did not wrap");
	property p_flag_next;
		@(posedge clk) disable iff (rst)
		chk_ma_r && tick |=> flags_r[timer8_pkg::FLAG_MA];
	endproperty
	a_flag_next: assert property (p_flag_next) // [RULE24]
		else $error("match flag not set at next tick");
	property p_com_off;
		@(posedge clk) disable iff (rst)
		com[0] == timer8_pkg::COM_OFF |=> oc_r[0] == $past(oc_r[0]);
	endproperty
	a_com_off: assert property (p_com_off) // [RULE4]
		else $error("output moved with mode off");
	property p_buffer;
		@(posedge clk) disable iff (rst)
		is_pwm && !wrap |=> $stable(ocr_r[0]);
	endproperty
	a_buffer: assert property (p_buffer) // [RULE23]
		else $error("pwm compare changed off top");
	c_ctc_match: cover property (@(posedge clk) is_ctc && match[0]);
	c_pwm_wrap:  cover property (@(posedge clk) wrap && com[0] == 2'h2);
	c_force:     cover property (@(posedge clk) force_s[0] && !is_pwm);
	c_blocked:   cover property (@(posedge clk) block_r && tick);
endmodule
`default_nettype wire

// *** timer8_pkg.sv ***
// constants and types for the 8-bit waveform timer
`default_nettype none
package timer8_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] COUNT_OFS  = 8'h04;
	localparam logic [7:0] CMP_A_OFS  = 8'h08;
	localparam logic [7:0] CMP_B_OFS  = 8'h0C;
	localparam logic [7:0] FLAGS_OFS  = 8'h10;
	localparam logic [7:0] FORCE_OFS  = 8'h14;
	localparam logic [7:0] PORT_OFS   = 8'h18;
	localparam logic [7:0] STATE_OFS  = 8'h1C;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_MA  = 1;
	localparam int FLAG_MB  = 2;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	typedef enum logic [2:0] {
		WM_NORMAL = 3'b000,
		WM_CTC    = 3'b010,
		WM_FAST   = 3'b011,
		WM_FASTA  = 3'b111
	} wave_mode_t;

	// control register layout, bits 15..0
	typedef struct packed {
		logic [4:0] spare_hi;
		logic [2:0] clock_select_field;
		logic       spare_lo;
		logic [2:0] waveform_mode_select;
		logic [1:0] channel_b_output_mode;
		logic [1:0] channel_a_output_mode;
	} ctrl_t;
endpackage
`default_nettype wire

// *** pin_load.sv ***
// load model on one waveform pin, pulled up while undriven
`default_nettype none
module pin_load (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      level
);
	timeunit 1ns;
	timeprecision 100ps;
	assign level = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

// *** test_timer8_waveform.sv ***
// self-checking bench for the 8-bit waveform timer
`default_nettype none
module test_timer8_waveform;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst, tick;
	logic [2:0]  svc;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        arvalid, arready, rvalid, rready;
	logic        pa, pa_oe, pb, pb_oe, lv_a, lv_b;
	int          error_cnt = 0;
	int          checked = 0;

	timer8_waveform timer8_waveform_i (
		.clk(clk), .rst(rst), .timer_tick(tick), .flag_serviced(svc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_a_out(pa), .pin_a_oe(pa_oe), .pin_b_out(pb), .pin_b_oe(pb_oe)
	);
	pin_load pin_load_i (.pin_out(pa), .pin_oe(pa_oe), .level(lv_a));
	pin_load pin_load_b_i (.pin_out(pb), .pin_oe(pb_oe), .level(lv_b));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic complete_run;
		if (error_cnt == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		resp = rresp;
		chk(rdata, {24'h00_0000, e});
	endtask

	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask

	// e is drive enable a, pin a, load level b, load level a
	task automatic pn(input logic [3:0] e);
		repeat (3) @(posedge clk);
		chk(32'({pa_oe, pa, lv_b, lv_a}), 32'(e));
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run;
	end

	initial begin
		rst = 1'b1;
		tick = 1'b0;
		svc = 3'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(timer8_pkg::CTRL_OFS, 8'h00);
		rd(timer8_pkg::COUNT_OFS, 8'h00);
		rd(8'h20, 8'h00);
		chk(32'(resp), 32'(timer8_pkg::RESP_SLVERR));
		wr(8'h21, 16'h00FF);
		chk(32'(resp), 32'(timer8_pkg::RESP_SLVERR));
		// port override and force strobe
		wr(8'h18, 16'h000F);
		pn(4'hF);
		wr(8'h00, 16'h0003);
		pn(4'hA);
		wr(8'h14, 16'h0001);
		rd(8'h1C, 8'h01);
		pn(4'hF);
		wr(8'h00, 16'h0002);
		rd(8'h1C, 8'h01);
		wr(8'h00, 16'h0000);
		wr(8'h14, 16'h0001);
		rd(8'h1C, 8'h01);
		wr(8'h18, 16'h0002);
		pn(4'h3);
		// normal mode wrap, flags, stop, write blocking
		wr(8'h04, 16'h00FE);
		wr(8'h00, 16'h0100);
		tk(2);
		rd(8'h04, 8'h00);
		rd(8'h10, 8'h01);
		@(posedge clk);
		svc <= 3'h1;
		@(posedge clk);
		svc <= 3'h0;
		rd(8'h10, 8'h00);
		wr(8'h00, 16'h0000);
		tk(3);
		rd(8'h04, 8'h00);
		wr(8'h04, 16'h0055);
		rd(8'h04, 8'h55);
		wr(8'h08, 16'h0055);
		wr(8'h04, 16'h0055);
		wr(8'h00, 16'h0100);
		tk(2);
		rd(8'h10, 8'h00);
		// clear on compare with toggle on channel a
		wr(8'h00, 16'h0020);
		wr(8'h08, 16'h0003);
		wr(8'h04, 16'h0000);
		wr(8'h10, 16'h0007);
		wr(8'h00, 16'h0121);
		tk(13);
		rd(8'h04, 8'h01);
		rd(8'h10, 8'h06);
		rd(8'h1C, 8'h00);
		wr(8'h10, 16'h0002);
		rd(8'h10, 8'h04);
		wr(8'h04, 16'h0010);
		wr(8'h10, 16'h0007);
		tk(240);
		rd(8'h04, 8'h00);
		rd(8'h10, 8'h05);
		// fast pwm, top fixed then top from compare a
		wr(8'h00, 16'h0032);
		wr(8'h08, 16'h0080);
		rd(8'h08, 8'h80);
		wr(8'h04, 16'h00FD);
		wr(8'h10, 16'h0007);
		wr(8'h00, 16'h0132);
		tk(3);
		rd(8'h04, 8'h00);
		rd(8'h10, 8'h01);
		rd(8'h1C, 8'h01);
		tk(129);
		rd(8'h1C, 8'h00);
		wr(8'h00, 16'h0070);
		wr(8'h04, 16'h007E);
		wr(8'h00, 16'h0170);
		tk(3);
		rd(8'h04, 8'h00);
		// inverted fast pwm with compare at max stays low
		wr(8'h00, 16'h0033);
		wr(8'h08, 16'h00FF);
		wr(8'h04, 16'h00FE);
		wr(8'h00, 16'h0133);
		tk(258);
		rd(8'h1C, 8'h00);
		complete_run;
	end
endmodule
`default_nettype wire
